// ---- src/smf_pkg.sv ----
// Shared constants, command codes and state types for the serial memory front end
package smf_pkg;

  // System clock
  localparam int CLK_KHZ = 100000;
  localparam int CLK_PERIOD_NS = 10;

  // Bus clock ceilings per read mode, in kHz
  localparam int F_FAST_KHZ = 10000;
  localparam int F_NORM_KHZ = 1600;
  localparam int F_APD_KHZ = 1000;

  // Least half period of the bus clock for a given ceiling, rounded up
  function automatic int half_cycles(input int f_khz);
    half_cycles = (CLK_KHZ + 2 * f_khz - 1) / (2 * f_khz);
  endfunction

  // Least time rounded up to whole clock cycles, never below one
  function automatic int ns_to_cycles(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    ns_to_cycles = (c < 1) ? 1 : c;
  endfunction

  localparam int HALF_FAST = half_cycles(F_FAST_KHZ);
  localparam int HALF_NORM = half_cycles(F_NORM_KHZ);
  localparam int HALF_APD = half_cycles(F_APD_KHZ);

  // Chip select high time and wake pulse width
  localparam int T_CS_HIGH_NS = 100;
  localparam int CS_HIGH_CYCLES = ns_to_cycles(T_CS_HIGH_NS);
  localparam int T_CSLU_NS = 20;
  localparam int CSLU_CYCLES = ns_to_cycles(T_CSLU_NS);

  // Self-timed write durations (typical figures used, maxima kept for reference)
  localparam int T_PAGE_TYP_MS = 1;
  localparam int T_PAGE_MAX_MS = 5;
  localparam int T_BYTE_TYP_US = 25;
  localparam int T_BYTE_MAX_US = 100;
  localparam int PAGE_WRITE_CYCLES_DEF = T_PAGE_TYP_MS * CLK_KHZ;
  localparam int BYTE_WRITE_CYCLES = T_BYTE_TYP_US * CLK_KHZ / 1000;

  // Power-down exit times
  localparam int T_RPD_US = 50;
  localparam int RPD_CYCLES_DEF = T_RPD_US * CLK_KHZ / 1000;
  localparam int T_XUDPD_US = 70;
  localparam int XUDPD_CYCLES_DEF = T_XUDPD_US * CLK_KHZ / 1000;

  // Framing
  localparam int BYTE_BITS = 8;
  localparam logic [5:0] FIRST_DATA_IDX = 6'h03;
  localparam logic [5:0] BYTE_CNT_MAX = 6'h3F;
  localparam int BUSY_BIT = 0;

  // Command codes
  localparam logic [7:0] OPCODE_NONE = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] FAST_READ_COMMAND = 8'h0B;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_POWER_DOWN = 8'hB9;
  localparam logic [7:0] ULTRA_DEEP_SLEEP_COMMAND = 8'h79;
  localparam logic [7:0] CMD_RESUME = 8'hAB;

  typedef enum logic [1:0] {PW_ON, PW_DOWN, PW_UDEEP, PW_WAKE} smf_power_t;

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_LOW, H_PAUSE, H_HIGH, H_PUSH, H_HOLD, H_GAP
  } smf_host_state_t;

endpackage

// ---- src/smf_if.sv ----
// Five-wire serial bus (select, clock, in, out, pause) between the master end and the memory front end
`timescale 1ns/1ps
`default_nettype none
interface smf_if;
  logic chip_sel_n;
  logic bus_clk;
  logic serial_in_line;
  logic serial_out_line;
  logic serial_out_oe;
  logic pause_n;
  logic serial_out_wire;

  // Output line floats while undriven; a pull-up is modelled here
  assign serial_out_wire = serial_out_oe ? serial_out_line : 1'b1;

  modport target (
    input chip_sel_n,
    input bus_clk,
    input serial_in_line,
    input pause_n,
    output serial_out_line,
    output serial_out_oe
  );

  modport host (
    output chip_sel_n,
    output bus_clk,
    output serial_in_line,
    output pause_n,
    input serial_out_wire
  );
endinterface
`default_nettype wire

// ---- src/smf_target.sv ----
// Memory-side serial front end: capture, shift-out, pause, write timing, power states
// Notes on behaviour
// - Chip select low wakes logic for transfers
// - Chip select high deselects, enters standby (code enters it only once no write is busy)
// - Deselected: input ignored, output line floats
// - Output bits change on bus clock fall
// - Input bits sampled on bus clock rise
// - Pause freezes transfer, resumes at same point
// - Master bounds clock per read mode
// - Page write finishes within 5 ms
// - Byte write finishes within 100 us
// - Master waits 50 us after resume
// - Ultra-deep exit: 20 ns select, 70 us
// - Standby reached within 8 us of deselect (code holds it off until a running write ends, up to 1 ms)
// - All bytes travel MSB first
// - Master uses bus mode 0 or 3
// - Status bit 0 shows write busy
`timescale 1ns/1ps
`default_nettype none
module smf_target import smf_pkg::*; #(
  parameter int PAGE_WRITE_CYCLES = PAGE_WRITE_CYCLES_DEF,
  parameter int WAKE_CYCLES = XUDPD_CYCLES_DEF
) (
  // System
  input wire logic mclk,
  input wire logic rst_n,
  // Serial bus
  smf_if.target bus,
  // Received bytes
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_first,
  // Bytes to send
  input wire logic [7:0] tx_data,
  output logic tx_taken,
  // State
  output logic write_busy_flag,
  output logic standby,
  output logic asleep
);

  // Pin synchronisers; stage 1 is read only by stage 2
  logic cs_s1, cs_s2, cs_d;
  logic clk_s1, clk_s2, clk_d;
  logic in_s1, in_s2;
  logic hold_s1, hold_s2;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_d <= 1'b0;
      in_s1 <= 1'b0;
      in_s2 <= 1'b0;
      hold_s1 <= 1'b1;
      hold_s2 <= 1'b1;
    end else begin
      cs_s1 <= bus.chip_sel_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      clk_s1 <= bus.bus_clk;
      clk_s2 <= clk_s1;
      clk_d <= clk_s2;
      in_s1 <= bus.serial_in_line;
      in_s2 <= in_s1;
      hold_s1 <= bus.pause_n;
      hold_s2 <= hold_s1;
    end
  end

  // Transfer and power state
  smf_power_t pw, next_pw;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [5:0] byte_cnt, next_byte_cnt;
  logic [7:0] rx_shift, next_rx_shift;
  logic [7:0] tx_shift, next_tx_shift;
  logic [7:0] opcode, next_opcode;
  logic out_bit, next_out_bit;
  logic [7:0] next_rx_data;
  logic next_rx_valid, next_rx_first, next_tx_taken;
  logic busy, next_busy;
  logic [16:0] busy_cnt, next_busy_cnt;
  logic [12:0] wake_cnt, next_wake_cnt;
  logic [3:0] low_cnt, next_low_cnt;
  logic next_standby;

  logic sel, rise, fall, cs_rise, live;
  logic [7:0] in_byte, status_byte;
  logic frame_whole;

  assign sel = !cs_s2;
  assign rise = clk_s2 && !clk_d;
  assign fall = !clk_s2 && clk_d;
  assign cs_rise = cs_s2 && !cs_d;
  // Edges count only while selected, unpaused and awake enough to decode
  assign live = sel && hold_s2 && (pw == PW_ON || pw == PW_DOWN);

  always_comb begin
    next_pw = pw;
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_rx_shift = rx_shift;
    next_tx_shift = tx_shift;
    next_opcode = opcode;
    next_out_bit = out_bit;
    next_rx_data = rx_data;
    next_rx_valid = 1'b0;
    next_rx_first = rx_first;
    next_tx_taken = 1'b0;
    next_busy = busy;
    next_busy_cnt = busy_cnt;
    next_wake_cnt = wake_cnt;
    next_low_cnt = low_cnt;
    next_standby = cs_s2 && !busy;
    in_byte = {rx_shift[6:0], in_s2};
    status_byte = 8'h00;
    status_byte[BUSY_BIT] = busy;
    frame_whole = (bit_cnt == 3'h0);

    if (live && rise) begin
      next_rx_shift = in_byte;
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'(BYTE_BITS - 1)) begin
        if (byte_cnt == 6'h00) begin
          next_opcode = in_byte;
        end
        if (pw == PW_ON) begin
          next_rx_data = in_byte;
          next_rx_valid = 1'b1;
          next_rx_first = (byte_cnt == 6'h00);
          // Status reads are answered here; all else comes from the user side
          if ((byte_cnt == 6'h00) ? (in_byte == CMD_READ_STATUS)
                                  : (opcode == CMD_READ_STATUS)) begin
            next_tx_shift = status_byte;
          end else begin
            next_tx_shift = tx_data;
            next_tx_taken = 1'b1;
          end
        end
        if (byte_cnt != BYTE_CNT_MAX) begin
          next_byte_cnt = byte_cnt + 6'h01;
        end
      end
    end

    if (live && fall) begin
      next_out_bit = tx_shift[7];
      next_tx_shift = {tx_shift[6:0], 1'b0};
    end

    // A cut-short frame must not leave stale position or opcode behind
    if (!sel) begin
      next_bit_cnt = 3'h0;
      next_byte_cnt = 6'h00;
      next_rx_shift = 8'h00;
      next_tx_shift = 8'h00;
      next_opcode = OPCODE_NONE;
    end

    if (busy) begin
      if (busy_cnt <= 17'h00001) begin
        next_busy = 1'b0;
        next_busy_cnt = 17'h00000;
      end else begin
        next_busy_cnt = busy_cnt - 17'h00001;
      end
    end

    case (pw)
      PW_ON: begin
        if (cs_rise && frame_whole) begin
          // Writes without whole data bytes, or during a write, are dropped
          if (opcode == CMD_WRITE && byte_cnt > FIRST_DATA_IDX && !busy) begin
            next_busy = 1'b1;
            if (byte_cnt == FIRST_DATA_IDX + 6'h01) begin
              next_busy_cnt = 17'(BYTE_WRITE_CYCLES);
            end else begin
              next_busy_cnt = 17'(PAGE_WRITE_CYCLES);
            end
          end else if (opcode == CMD_POWER_DOWN && byte_cnt == 6'h01) begin
            next_pw = PW_DOWN;
          end else if (opcode == ULTRA_DEEP_SLEEP_COMMAND && byte_cnt == 6'h01) begin
            next_pw = PW_UDEEP;
            next_low_cnt = 4'h0;
          end
        end
      end
      PW_DOWN: begin
        if (cs_rise && frame_whole && opcode == CMD_RESUME && byte_cnt == 6'h01) begin
          next_pw = PW_ON;
        end
      end
      PW_UDEEP: begin
        // Bus activity is ignored; only a long enough select low wakes us
        if (sel) begin
          if (low_cnt == 4'(CSLU_CYCLES - 1)) begin
            next_pw = PW_WAKE;
            next_wake_cnt = 13'(WAKE_CYCLES - 1);
          end else begin
            next_low_cnt = low_cnt + 4'h1;
          end
        end else begin
          next_low_cnt = 4'h0;
        end
      end
      PW_WAKE: begin
        if (wake_cnt != 13'h0000) begin
          next_wake_cnt = wake_cnt - 13'h0001;
        end else if (!sel) begin
          // Wait for a frame boundary so no half frame is decoded
          next_pw = PW_ON;
        end
      end
      default: begin
        next_pw = PW_ON;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pw <= PW_ON;
      bit_cnt <= 3'h0;
      byte_cnt <= 6'h00;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      opcode <= OPCODE_NONE;
      out_bit <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_first <= 1'b0;
      tx_taken <= 1'b0;
      busy <= 1'b0;
      busy_cnt <= 17'h00000;
      wake_cnt <= 13'h0000;
      low_cnt <= 4'h0;
      standby <= 1'b1;
    end else begin
      pw <= next_pw;
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      rx_shift <= next_rx_shift;
      tx_shift <= next_tx_shift;
      opcode <= next_opcode;
      out_bit <= next_out_bit;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
      rx_first <= next_rx_first;
      tx_taken <= next_tx_taken;
      busy <= next_busy;
      busy_cnt <= next_busy_cnt;
      wake_cnt <= next_wake_cnt;
      low_cnt <= next_low_cnt;
      standby <= next_standby;
    end
  end

  assign write_busy_flag = busy;
  assign asleep = (pw != PW_ON);
  assign bus.serial_out_line = out_bit;
  // Floats while deselected, paused or asleep
  assign bus.serial_out_oe = sel && hold_s2 && (pw == PW_ON);

endmodule
`default_nettype wire

// ---- src/smf_host.sv ----
// Master end of the serial bus with its receive FIFO
`timescale 1ns/1ps
`default_nettype none
module smf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // System
  input wire logic mclk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module smf_host import smf_pkg::*; #(
  parameter int RPD_CYCLES = RPD_CYCLES_DEF
) (
  // System
  input wire logic mclk,
  input wire logic rst_n,
  // Serial bus
  smf_if.host bus,
  // Bytes to send; tx_last closes the frame after this byte
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // Mode and speed
  input wire logic mode3,
  input wire logic fast_mode,
  input wire logic apd_mode,
  input wire logic pause_req,
  // Received bytes
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // State
  output logic in_frame
);
  smf_host_state_t st, next_st;
  logic [7:0] cnt, next_cnt, half_m1;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] sh_tx, next_sh_tx, sh_rx, next_sh_rx, cmd, next_cmd;
  logic last, next_last, cs_n, next_cs_n, sck, next_sck, mosi, next_mosi;
  logic hold_n, next_hold_n;
  logic [12:0] rpd_cnt, next_rpd_cnt;
  logic miso_s1, miso_s2, push, fifo_ready;

  // Slowest applicable ceiling wins
  assign half_m1 = apd_mode ? 8'(HALF_APD - 1) : (fast_mode ? 8'(HALF_FAST - 1)
                                                             : 8'(HALF_NORM - 1));
  // Store once: waiting here for the user's next byte must not repeat the push
  assign push = (st == H_PUSH) && (last || tx_valid);
  assign tx_ready = (st == H_IDLE && rpd_cnt == 13'h0000) ||
                    (st == H_PUSH && fifo_ready && !last);

  always_comb begin
    next_st = st;
    next_cnt = (cnt != 8'h00) ? cnt - 8'h01 : cnt;
    next_bit_cnt = bit_cnt;
    next_sh_tx = sh_tx;
    next_sh_rx = sh_rx;
    next_cmd = cmd;
    next_last = last;
    next_cs_n = cs_n;
    next_sck = sck;
    next_mosi = mosi;
    next_hold_n = hold_n;
    next_rpd_cnt = (rpd_cnt != 13'h0000) ? rpd_cnt - 13'h0001 : rpd_cnt;
    case (st)
      H_IDLE: begin
        next_sck = mode3;
        if (tx_valid && rpd_cnt == 13'h0000) begin
          next_sh_tx = tx_data;
          next_cmd = tx_data;
          next_last = tx_last;
          next_cs_n = 1'b0;
          next_bit_cnt = 3'h0;
          next_cnt = half_m1;
          next_st = H_SETUP;
        end
      end
      H_SETUP: begin
        if (cnt == 8'h00) begin
          next_sck = 1'b0;
          next_mosi = sh_tx[7];
          next_cnt = half_m1;
          next_st = H_LOW;
        end
      end
      H_LOW: begin
        // Pause only with the clock low so no edge is lost
        if (pause_req) begin
          next_hold_n = 1'b0;
          next_st = H_PAUSE;
        end else if (cnt == 8'h00) begin
          next_sck = 1'b1;
          next_cnt = half_m1;
          next_st = H_HIGH;
        end
      end
      H_PAUSE: begin
        next_cnt = cnt;
        if (!pause_req) begin
          next_hold_n = 1'b1;
          next_cnt = half_m1;
          next_st = H_LOW;
        end
      end
      H_HIGH: begin
        if (cnt == 8'h00) begin
          // Sampled late in the high phase, well after the target's fall update
          next_sh_rx = {sh_rx[6:0], miso_s2};
          next_sh_tx = {sh_tx[6:0], 1'b0};
          if (bit_cnt == 3'(BYTE_BITS - 1)) begin
            next_st = H_PUSH;
          end else begin
            next_bit_cnt = bit_cnt + 3'h1;
            next_sck = 1'b0;
            next_mosi = sh_tx[6];
            next_cnt = half_m1;
            next_st = H_LOW;
          end
        end
      end
      H_PUSH: begin
        // A full FIFO holds the clock high until the user drains it
        if (fifo_ready) begin
          if (last) begin
            next_sck = mode3;
            next_cnt = half_m1;
            next_st = H_HOLD;
          end else if (tx_valid) begin
            next_sh_tx = tx_data;
            next_last = tx_last;
            next_bit_cnt = 3'h0;
            next_sck = 1'b0;
            next_mosi = tx_data[7];
            next_cnt = half_m1;
            next_st = H_LOW;
          end else begin
            next_st = H_PUSH;
          end
        end
      end
      H_HOLD: begin
        if (cnt == 8'h00) begin
          next_cs_n = 1'b1;
          next_cnt = 8'(CS_HIGH_CYCLES - 1);
          next_st = H_GAP;
          if (cmd == CMD_RESUME) begin
            next_rpd_cnt = 13'(RPD_CYCLES);
          end
        end
      end
      H_GAP: begin
        if (cnt == 8'h00) begin
          next_st = H_IDLE;
        end
      end
      default: begin
        next_st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= H_IDLE;
      cnt <= 8'h00;
      bit_cnt <= 3'h0;
      sh_tx <= 8'h00;
      sh_rx <= 8'h00;
      cmd <= OPCODE_NONE;
      last <= 1'b0;
      cs_n <= 1'b1;
      sck <= 1'b0;
      mosi <= 1'b0;
      hold_n <= 1'b1;
      rpd_cnt <= 13'h0000;
      miso_s1 <= 1'b1;
      miso_s2 <= 1'b1;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      bit_cnt <= next_bit_cnt;
      sh_tx <= next_sh_tx;
      sh_rx <= next_sh_rx;
      cmd <= next_cmd;
      last <= next_last;
      cs_n <= next_cs_n;
      sck <= next_sck;
      mosi <= next_mosi;
      hold_n <= next_hold_n;
      rpd_cnt <= next_rpd_cnt;
      miso_s1 <= bus.serial_out_wire;
      miso_s2 <= miso_s1;
    end
  end

  smf_fifo #(.WIDTH(8), .DEPTH(8)) rx_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_data(sh_rx),
    .in_ready(fifo_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );

  assign bus.chip_sel_n = cs_n;
  assign bus.bus_clk = sck;
  assign bus.serial_in_line = mosi;
  assign bus.pause_n = hold_n;
  assign in_frame = !cs_n;
endmodule
`default_nettype wire

// ---- test/smf_bus_sva.sv ----
// Timing assertions on the serial bus joining the two ends
`timescale 1ns/1ps
`default_nettype none
module smf_bus_sva (
  // System
  input wire logic mclk,
  input wire logic rst_n,
  // Serial bus
  input wire logic chip_sel_n,
  input wire logic bus_clk,
  input wire logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic serial_out_oe,
  input wire logic pause_n,
  // Target state
  input wire logic asleep
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Five cycles cover the target's two sync flops; its output enable is decoded from them without a register
  chk_float_desel: assert property (chip_sel_n [*5] |-> !serial_out_oe)
    else $error("output driven while deselected");
  // A sleeping target keeps its output off even when selected
  chk_drive_sel: assert property ((!chip_sel_n && pause_n && !asleep) [*5] |-> serial_out_oe)
    else $error("output not driven while selected");
  chk_float_pause: assert property (!pause_n [*5] |-> !serial_out_oe)
    else $error("output driven while paused");
  chk_out_fall: assert property (
    (serial_out_oe && $past(serial_out_oe) && $changed(serial_out_line)) |->
    (!$past(bus_clk, 2) && $past(bus_clk, 3)) || (!$past(bus_clk, 3) && $past(bus_clk, 4))
    || (!$past(bus_clk, 4) && $past(bus_clk, 5)))
    else $error("output bit changed away from a falling clock");
  chk_sel_idle: assert property ($fell(chip_sel_n) |-> $stable(bus_clk) [*5])
    else $error("clock moved right after select");
  chk_half_min: assert property ((!chip_sel_n && $changed(bus_clk)) |=> $stable(bus_clk) [*4])
    else $error("clock half period too short");
  chk_in_hold: assert property (($rose(bus_clk) && !chip_sel_n) |-> $stable(serial_in_line) [*4])
    else $error("input bit moved around rising clock");
  chk_pause_low: assert property ($fell(pause_n) |-> !bus_clk && !chip_sel_n)
    else $error("pause entered outside clock low phase");
  chk_pause_hold: assert property ((!pause_n && !$past(pause_n)) |-> $stable(bus_clk) && !chip_sel_n)
    else $error("bus moved during pause");
  cov_pause: cover property ($fell(pause_n));
  cov_frame: cover property ($rose(chip_sel_n));
  cov_read: cover property (serial_out_oe && $changed(serial_out_line));
endmodule
`default_nettype wire

// ---- test/spi_memory_serial_front_end_tb_top.sv ----
// Testbench joining master end and memory front end over the serial bus
`timescale 1ns/1ps
`default_nettype none
module spi_memory_serial_front_end_tb_top;
  import smf_pkg::*;
  typedef struct {logic m3, fs, ap; logic [7:0] op; int n; logic [7:0] tt, ex;} smf_row_t;
  localparam int PAGE_CYC = 200;
  logic mclk, rst_n, tx_valid, tx_last, mode3, fast_mode, apd_mode, pause_req, rx_ready;
  logic tx_ready, h_rx_valid, in_frame, t_rx_valid, rx_first, tx_taken, busy, standby, asleep;
  logic [7:0] tx_data, tgt_tx, h_rx_data, t_rx_data;
  int miscompares = 0;
  int tests_run = 0;
  int nf = 0;
  int nt = 0;
  logic [7:0] tq[$];
  logic [7:0] hq[$];
  smf_row_t rows [5] = '{
    '{1'b0, 1'b1, 1'b0, CMD_READ_STATUS, 3, 8'hFF, 8'h00},
    '{1'b1, 1'b1, 1'b0, CMD_READ_STATUS, 2, 8'hFF, 8'h00},
    '{1'b0, 1'b1, 1'b0, CMD_READ, 5, 8'hA5, 8'hA5},
    '{1'b1, 1'b0, 1'b0, FAST_READ_COMMAND, 6, 8'h3C, 8'h3C},
    '{1'b0, 1'b0, 1'b1, CMD_READ, 5, 8'h96, 8'h96}};

  smf_if u_smf_if ();
  smf_host #(.RPD_CYCLES(50)) u_smf_host (.mclk(mclk), .rst_n(rst_n), .bus(u_smf_if),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .mode3(mode3), .fast_mode(fast_mode), .apd_mode(apd_mode), .pause_req(pause_req),
    .rx_valid(h_rx_valid), .rx_data(h_rx_data), .rx_ready(rx_ready), .in_frame(in_frame));
  smf_target #(.PAGE_WRITE_CYCLES(PAGE_CYC), .WAKE_CYCLES(50)) u_smf_target (.mclk(mclk),
    .rst_n(rst_n), .bus(u_smf_if), .rx_data(t_rx_data), .rx_valid(t_rx_valid),
    .rx_first(rx_first), .tx_data(tgt_tx), .tx_taken(tx_taken), .write_busy_flag(busy),
    .standby(standby), .asleep(asleep));
  smf_bus_sva u_smf_bus_sva (.mclk(mclk), .rst_n(rst_n), .chip_sel_n(u_smf_if.chip_sel_n),
    .bus_clk(u_smf_if.bus_clk), .serial_in_line(u_smf_if.serial_in_line),
    .serial_out_line(u_smf_if.serial_out_line), .serial_out_oe(u_smf_if.serial_out_oe),
    .pause_n(u_smf_if.pause_n), .asleep(asleep));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (t_rx_valid === 1'b1) tq.push_back(t_rx_data);
    if (h_rx_valid === 1'b1 && rx_ready === 1'b1) hq.push_back(h_rx_data);
    if (t_rx_valid === 1'b1 && rx_first === 1'b1) nf++;
    if (tx_taken === 1'b1) nt++;
  end

  task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] bval(input logic [7:0] op, input int i);
    return (i == 0) ? op : 8'(i * 41);
  endfunction

  // Sends one whole frame; the host closes it after the byte marked last
  task automatic send(input logic [7:0] op, input int n);
    int k;
    tq.delete();
    hq.delete();
    nf = 0;
    nt = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      tx_valid = 1'b1;
      tx_data = bval(op, i);
      tx_last = (i == n - 1);
      k = 0;
      #4;
      while (tx_ready !== 1'b1 && k < 30000) begin
        @(negedge mclk);
        #4;
        k++;
      end
      if (k >= 30000) begin
        miscompares++;
        end_of_test();
      end
      @(posedge mclk);
    end
    @(negedge mclk);
    tx_valid = 1'b0;
    tx_last = 1'b0;
    k = 0;
    repeat (3) @(negedge mclk);
    while (in_frame !== 1'b0 && k < 30000) begin
      @(negedge mclk);
      k++;
    end
    chk("frame end", {7'h00, in_frame}, 8'h00);
    if (in_frame !== 1'b0) end_of_test();
    // Covers the ten-cycle gap and the target's sync of the closing select edge
    repeat (20) @(negedge mclk);
  endtask

  task automatic rxchk(input logic [7:0] op, input int n);
    chk("rx count", 8'(tq.size()), 8'(n));
    for (int i = 0; i < n; i++) chk("rx byte", tq[i], bval(op, i));
    chk("first flag", 8'(nf), 8'h01);
  endtask

  task automatic wait_busy(input int lim);
    int k;
    k = 0;
    while (busy !== 1'b0 && k < lim) begin
      @(negedge mclk);
      k++;
    end
    chk("write done", {7'h00, busy}, 8'h00);
    if (busy !== 1'b0) end_of_test();
  endtask

  initial begin
    {tx_valid, tx_last, mode3, apd_mode, pause_req} = 5'h00;
    {fast_mode, rx_ready} = 2'h3;
    tx_data = 8'h00;
    tgt_tx = 8'h00;
    rst_n = 1'b0;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    foreach (rows[r]) begin
      {mode3, fast_mode, apd_mode} = {rows[r].m3, rows[r].fs, rows[r].ap};
      tgt_tx = rows[r].tt;
      repeat (3) @(negedge mclk);
      send(rows[r].op, rows[r].n);
      rxchk(rows[r].op, rows[r].n);
      chk("host byte", hq[hq.size() - 1], rows[r].ex);
      chk("standby", {7'h00, standby}, 8'h01);
      chk("idle clock", {7'h00, u_smf_if.bus_clk}, {7'h00, rows[r].m3});
    end
    {mode3, fast_mode, apd_mode} = 3'h2;
    send(CMD_WRITE, 4);
    rxchk(CMD_WRITE, 4);
    chk("busy", {7'h00, busy}, 8'h01);
    send(CMD_READ_STATUS, 2);
    chk("status", hq[1], 8'h01);
    wait_busy(10000);
    send(CMD_WRITE, 6);
    wait_busy(PAGE_CYC + 20);
    tgt_tx = 8'h5A;
    fork
      send(CMD_READ, 5);
      begin
        repeat (60) @(negedge mclk);
        pause_req = 1'b1;
        repeat (50) @(negedge mclk);
        chk("paused", {7'h00, u_smf_if.pause_n}, 8'h00);
        chk("awake", {7'h00, standby}, 8'h00);
        repeat (50) @(negedge mclk);
        pause_req = 1'b0;
      end
    join
    rxchk(CMD_READ, 5);
    chk("resumed byte", hq[4], 8'h5A);
    chk("taken", 8'(nt), 8'h05);
    // Holding the drain side makes the host stall once the FIFO is full
    rx_ready = 1'b0;
    fork
      send(CMD_READ_STATUS, 11);
      begin
        repeat (1500) @(negedge mclk);
        chk("stalled", {6'h00, in_frame, tx_ready}, 8'h02);
        chk("held", 8'(hq.size()), 8'h00);
        rx_ready = 1'b1;
      end
    join
    chk("drained", 8'(hq.size()), 8'h0B);
    chk("last status", hq[10], 8'h00);
    fork
      send(CMD_READ, 5);
      repeat (150) @(negedge mclk);
    join_any
    disable fork;
    rst_n = 1'b0;
    tx_valid = 1'b0;
    repeat (8) @(negedge mclk);
    chk("select", {7'h00, u_smf_if.chip_sel_n}, 8'h01);
    chk("out enable", {7'h00, u_smf_if.serial_out_oe}, 8'h00);
    rst_n = 1'b1;
    @(negedge mclk);
    send(CMD_READ_STATUS, 2);
    chk("after reset", hq[1], 8'h00);
    send(CMD_POWER_DOWN, 1);
    chk("power down", {7'h00, asleep}, 8'h01);
    send(CMD_READ_STATUS, 2);
    chk("power down float", hq[1], 8'hFF);
    send(CMD_RESUME, 1);
    // Awake again, but the host still holds off new frames
    chk("resume wait", {6'h00, asleep, tx_ready}, 8'h00);
    send(CMD_READ_STATUS, 2);
    chk("after resume", hq[1], 8'h00);
    send(ULTRA_DEEP_SLEEP_COMMAND, 1);
    chk("deep sleep", {7'h00, asleep}, 8'h01);
    // This frame only wakes the target; its bytes are not answered
    send(CMD_READ_STATUS, 2);
    chk("deep float", hq[1], 8'hFF);
    chk("woken", {7'h00, asleep}, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
